// *** hw/rdc_defs.svh ***
// Constants for the resolver converter host port: offsets, fields, reset values, counts
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

// ********************************
// Register byte offsets
// ********************************
`define RDC_CTRL_OFS 8'h00
`define RDC_STATUS_OFS 8'h04
`define RDC_POS_HOLD_OFS 8'h08
`define RDC_VEL_HOLD_OFS 8'h0c
`define RDC_FAULT_HOLD_OFS 8'h10
`define RDC_CFG_RX_OFS 8'h14
`define RDC_CFG_TX_OFS 8'h18
`define RDC_CFG_CLR_OFS 8'h1c

// ********************************
// Fields and reset values
// ********************************
`define RDC_CTRL_EN_BIT 0
`define RDC_CTRL_RESET 1'b1
`define RDC_CFG_TX_RESET 8'h00
`define RDC_CFG_CLR_BIT 0
`define RDC_ST_SERIAL_BIT 0
`define RDC_ST_MODE_LSB 1
`define RDC_ST_RES_LSB 3
`define RDC_ST_CFG_NEW_BIT 5
`define RDC_ST_FRAME_BIT 6
`define RDC_ST_RX_CNT_LSB 8

// ********************************
// Resolution masks (10/12/14/16 bits)
// ********************************
`define RDC_MASK_RES10 16'hffc0
`define RDC_MASK_RES12 16'hfff0
`define RDC_MASK_RES14 16'hfffc
`define RDC_MASK_RES16 16'hffff

// ********************************
// Serial frame and output enables
// ********************************
`define RDC_FRAME_BITS 24
`define RDC_RX_BITS 8
`define RDC_RX_CNT_W 5
`define RDC_OE_ALL 16'h0000
`define RDC_OE_SDO_ONLY 16'h7fff
`define RDC_OE_NONE 16'hffff

`endif

// *** hw/rdc_pkg.sv ***
// Types shared by the resolver converter host port
package rdc_pkg;

    typedef enum logic [1:0] {
        MODE_POSITION,
        MODE_RESERVED,
        MODE_VELOCITY,
        MODE_CONFIG
    } rdc_mode_t;

    typedef enum logic [1:0] {
        RES_10,
        RES_12,
        RES_14,
        RES_16
    } rdc_res_t;

endpackage : rdc_pkg

// *** hw/rdc_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module rdc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : rdc_sync

// *** hw/rdc_serial_shift.sv ***
// Serial frame shifter: loads a frame, shifts out MSB first, gathers input bits
`timescale 1ns/1ps
module rdc_serial_shift #(
    parameter int FRAME_W = 24,
    parameter int RX_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [FRAME_W-1:0] load_word,
    input wire logic shift_out,
    input wire logic sample_in,
    input wire logic sdi,
    output logic sdo,
    output logic [RX_W-1:0] rx_word
);
    logic [FRAME_W-1:0] tx_q;

    assign sdo = tx_q[FRAME_W-1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_q <= '0;
        end else if (load) begin
            tx_q <= load_word;
        end else if (shift_out) begin
            tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_word <= '0;
        end else if (sample_in) begin
            rx_word <= {rx_word[RX_W-2:0], sdi};
        end
    end
endmodule : rdc_serial_shift

// *** hw/rdc_host_port.sv ***
// Resolver converter host port: parallel/serial pin interface with AHB-Lite registers
//
// Contract
// - Port answers read and write/frame strobes only while device select is low; the capture strobe acts regardless.
// - Port-select high picks parallel interface, low picks serial interface.
// - Parallel mode drives the 16-bit bus only while select and read strobe low.
// - Read strobe falling edge frames a parallel read and latches the word.
// - Parallel write takes the low byte on the write strobe rising edge, with select low and config mode selected.
// - In serial mode the write/frame strobe with select frames the serial link.
// - Capture strobe falling edge copies position and velocity into holding registers.
// - Fault holding register refreshes on the same capture strobe falling edge.
// - Parallel mode: top two bus lines are three-state outputs gated by select and read strobe.
// - Serial mode: top line is serial out, next bit after each rising clock.
// - Serial mode: second line is serial input, gated by select and frame strobe.
// - Serial input bits are sampled on falling serial clock edges.
// - Resolution comes from the two resolution-select inputs.
// - Third line is serial clock input in serial mode, data output in parallel.
// - Low eight bus lines are bidirectional, steered by select and both strobes.
// - Two mode-select inputs choose what the port reads or writes.
`timescale 1ns/1ps
`include "rdc_defs.svh"
module rdc_host_port (
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Tracking loop contents (same clock)
    input wire logic [15:0] integ_position,
    input wire logic [15:0] integ_velocity,
    input wire logic [7:0] fault_flags,
    // Host pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic write_frame_strobe_n,
    input wire logic serial_port_select,
    input wire logic sample_n,
    input wire logic mode_select_hi,
    input wire logic mode_select_lo,
    input wire logic resolution_select_hi,
    input wire logic resolution_select_lo,
    input wire logic [15:0] parallel_data_bus_in,
    output logic [15:0] parallel_data_bus_out,
    output logic [15:0] parallel_data_bus_oe_n
);
    import rdc_pkg::*;

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [18:0] pins_raw;
    logic [18:0] pins_s;
    logic s_cs_n;
    logic s_rd_n;
    logic s_wfs_n;
    logic s_port_sel;
    logic s_sample_n;
    logic s_ms_hi;
    logic s_ms_lo;
    logic s_res_hi;
    logic s_res_lo;
    logic s_sdi;
    logic s_sclk;
    logic [7:0] s_low_byte;

    assign pins_raw = {cs_n, rd_n, write_frame_strobe_n, serial_port_select, sample_n,
                       mode_select_hi, mode_select_lo, resolution_select_hi,
                       resolution_select_lo, parallel_data_bus_in[14],
                       parallel_data_bus_in[13], parallel_data_bus_in[7:0]};

    rdc_sync #(
        .W(19),
        .INIT(19'h7ffff)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pins_raw),
        .q(pins_s)
    );

    assign s_cs_n = pins_s[18];
    assign s_rd_n = pins_s[17];
    assign s_wfs_n = pins_s[16];
    assign s_port_sel = pins_s[15];
    assign s_sample_n = pins_s[14];
    assign s_ms_hi = pins_s[13];
    assign s_ms_lo = pins_s[12];
    assign s_res_hi = pins_s[11];
    assign s_res_lo = pins_s[10];
    assign s_sdi = pins_s[9];
    assign s_sclk = pins_s[8];
    assign s_low_byte = pins_s[7:0];

    // ********************************
    // Edge detection
    // ********************************
    logic rd_n_prev_q;
    logic wfs_n_prev_q;
    logic sample_n_prev_q;
    logic sclk_prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_n_prev_q <= 1'b1;
            wfs_n_prev_q <= 1'b1;
            sample_n_prev_q <= 1'b1;
            sclk_prev_q <= 1'b1;
        end else begin
            rd_n_prev_q <= s_rd_n;
            wfs_n_prev_q <= s_wfs_n;
            sample_n_prev_q <= s_sample_n;
            sclk_prev_q <= s_sclk;
        end
    end

    wire rd_fall = rd_n_prev_q & ~s_rd_n;
    wire wfs_fall = wfs_n_prev_q & ~s_wfs_n;
    wire wfs_rise = ~wfs_n_prev_q & s_wfs_n;
    wire sample_fall = sample_n_prev_q & ~s_sample_n;
    wire sclk_rise = ~sclk_prev_q & s_sclk;
    wire sclk_fall = sclk_prev_q & ~s_sclk;

    // ********************************
    // Mode, resolution and select decode
    // ********************************
    logic port_en_q;
    rdc_mode_t mode;
    rdc_res_t res;
    logic [15:0] res_mask;

    wire selected = ~s_cs_n & port_en_q;
    wire par_mode = s_port_sel;
    wire ser_mode = ~s_port_sel;

    assign mode = rdc_mode_t'({s_ms_hi, s_ms_lo});
    assign res = rdc_res_t'({s_res_hi, s_res_lo});

    assign res_mask = (res == RES_10) ? `RDC_MASK_RES10 :
                      (res == RES_12) ? `RDC_MASK_RES12 :
                      (res == RES_14) ? `RDC_MASK_RES14 : `RDC_MASK_RES16;

    // ********************************
    // Holding registers
    // ********************************
    logic [15:0] pos_hold_q;
    logic [15:0] vel_hold_q;
    logic [7:0] fault_hold_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_hold_q <= 16'h0000;
            vel_hold_q <= 16'h0000;
            fault_hold_q <= 8'h00;
        end else if (sample_fall) begin
            pos_hold_q <= integ_position;
            vel_hold_q <= integ_velocity;
            fault_hold_q <= fault_flags;
        end
    end

    // ********************************
    // Read word selection
    // ********************************
    logic [15:0] read_word;
    logic [7:0] cfg_tx_q;

    always_comb begin
        case (mode)
            MODE_POSITION: read_word = pos_hold_q & res_mask;
            MODE_VELOCITY: read_word = vel_hold_q & res_mask;
            MODE_CONFIG: read_word = {cfg_tx_q, 8'h00};
            default: read_word = 16'h0000;
        endcase
    end

    // ********************************
    // Parallel read path
    // ********************************
    logic [15:0] par_word_q;

    wire par_read_start = rd_fall & selected & par_mode;
    wire par_drive = selected & par_mode & ~s_rd_n;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            par_word_q <= 16'h0000;
        end else if (par_read_start) begin
            par_word_q <= read_word;
        end
    end

    // ********************************
    // Serial frame
    // ********************************
    logic frame_active_q;
    logic [`RDC_RX_CNT_W-1:0] rx_cnt_q;
    rdc_mode_t frame_mode_q;
    logic sdo_bit;
    logic [7:0] rx_byte;

    // Read strobe is not looked at here; host keeps it high in serial mode
    wire ser_start = wfs_fall & selected & ser_mode;
    wire ser_end = frame_active_q & (wfs_rise | s_cs_n);
    wire ser_shift = frame_active_q & ~ser_end & sclk_rise;
    wire ser_sample = frame_active_q & ~ser_end & sclk_fall;
    wire ser_drive = selected & ser_mode & ~s_wfs_n;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_active_q <= 1'b0;
        end else if (ser_start) begin
            frame_active_q <= 1'b1;
        end else if (ser_end) begin
            frame_active_q <= 1'b0;
        end
    end

    // Mode is latched at frame start since the host holds it through readback
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_mode_q <= MODE_POSITION;
        end else if (ser_start) begin
            frame_mode_q <= mode;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_cnt_q <= '0;
        end else if (ser_start) begin
            rx_cnt_q <= '0;
        end else if (ser_sample && rx_cnt_q != `RDC_FRAME_BITS) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
        end
    end

    rdc_serial_shift #(
        .FRAME_W(`RDC_FRAME_BITS),
        .RX_W(`RDC_RX_BITS)
    ) u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .load(ser_start),
        .load_word({read_word, fault_hold_q}),
        .shift_out(ser_shift),
        .sample_in(ser_sample),
        .sdi(s_sdi),
        .sdo(sdo_bit),
        .rx_word(rx_byte)
    );

    // ********************************
    // Configuration byte from host
    // ********************************
    logic [7:0] cfg_rx_q;
    logic cfg_new_q;
    logic cfg_clr;

    wire par_write = wfs_rise & selected & par_mode & s_rd_n & (mode == MODE_CONFIG);
    wire ser_write = ser_end & (frame_mode_q == MODE_CONFIG) &
                     (rx_cnt_q >= `RDC_RX_CNT_W'(`RDC_RX_BITS));
    wire cfg_take = par_write | ser_write;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_rx_q <= 8'h00;
        end else if (par_write) begin
            cfg_rx_q <= s_low_byte;
        end else if (ser_write) begin
            cfg_rx_q <= rx_byte;
        end
    end

    // New byte wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_new_q <= 1'b0;
        end else if (cfg_take) begin
            cfg_new_q <= 1'b1;
        end else if (cfg_clr) begin
            cfg_new_q <= 1'b0;
        end
    end

    // ********************************
    // Pin output registers
    // ********************************
    logic [15:0] bus_out_d;
    logic [15:0] bus_oe_n_d;

    assign bus_out_d = par_mode ? par_word_q : {sdo_bit, 15'h0000};
    assign bus_oe_n_d = par_drive ? `RDC_OE_ALL :
                        ser_drive ? `RDC_OE_SDO_ONLY :
                        `RDC_OE_NONE;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            parallel_data_bus_out <= 16'h0000;
            parallel_data_bus_oe_n <= `RDC_OE_NONE;
        end else begin
            parallel_data_bus_out <= bus_out_d;
            parallel_data_bus_oe_n <= bus_oe_n_d;
        end
    end

    // ********************************
    // AHB-Lite slave
    // ********************************
    logic wr_pend_q;
    logic [7:0] waddr_q;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    wire ahb_take = hsel & htrans[1] & hready;
    wire ahb_wr = ahb_take & hwrite;
    wire ahb_rd = ahb_take & ~hwrite;
    wire [7:0] raddr = {haddr[7:2], 2'b00};

    assign status_word = {19'h00000, rx_cnt_q, 1'b0, frame_active_q, cfg_new_q,
                          res, mode, s_port_sel};

    always_comb begin
        case (raddr)
            `RDC_CTRL_OFS: rd_mux = {31'h00000000, port_en_q};
            `RDC_STATUS_OFS: rd_mux = status_word;
            `RDC_POS_HOLD_OFS: rd_mux = {16'h0000, pos_hold_q};
            `RDC_VEL_HOLD_OFS: rd_mux = {16'h0000, vel_hold_q};
            `RDC_FAULT_HOLD_OFS: rd_mux = {24'h000000, fault_hold_q};
            `RDC_CFG_RX_OFS: rd_mux = {24'h000000, cfg_rx_q};
            `RDC_CFG_TX_OFS: rd_mux = {24'h000000, cfg_tx_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            waddr_q <= 8'h00;
        end else begin
            wr_pend_q <= ahb_wr;
            waddr_q <= raddr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (ahb_rd) begin
            hrdata <= rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    wire wr_ctrl = wr_pend_q & (waddr_q == `RDC_CTRL_OFS);
    wire wr_cfg_tx = wr_pend_q & (waddr_q == `RDC_CFG_TX_OFS);
    assign cfg_clr = wr_pend_q & (waddr_q == `RDC_CFG_CLR_OFS) & hwdata[`RDC_CFG_CLR_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_en_q <= `RDC_CTRL_RESET;
            cfg_tx_q <= `RDC_CFG_TX_RESET;
        end else begin
            if (wr_ctrl) begin
                port_en_q <= hwdata[`RDC_CTRL_EN_BIT];
            end
            if (wr_cfg_tx) begin
                cfg_tx_q <= hwdata[7:0];
            end
        end
    end

    // hsize is accepted but only whole-word transfers are supported
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule : rdc_host_port

// *** testbench/rdc_host_port_asserts.sv ***
// Concurrent checks of the host port pin enables and bus answer
`timescale 1ns/1ps
module rdc_host_port_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic write_frame_strobe_n,
    input wire logic serial_port_select,
    input wire logic [15:0] parallel_data_bus_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic par = serial_port_select;
    wire logic [15:0] oe = parallel_data_bus_oe_n;
    a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not ready and OKAY");
    a_cs_releases: assert property (cs_n [*8] |-> oe == 16'hffff)
        else $error("bus driven while deselected");
    a_rd_releases: assert property ((par && rd_n) [*8] |-> oe == 16'hffff)
        else $error("bus driven without read strobe");
    a_rd_drives: assert property ((par && !cs_n && !rd_n) [*8] |-> oe == 16'h0000)
        else $error("read strobe did not enable bus");
    a_par_uniform: assert property (par [*8] |-> oe inside {16'h0000, 16'hffff})
        else $error("parallel bus partly driven");
    a_serial_lines: assert property (!par [*8] |-> oe[14:0] == 15'h7fff)
        else $error("serial input or clock line driven");
    a_sdo_release: assert property ((!par && (cs_n || write_frame_strobe_n)) [*8] |-> oe[15])
        else $error("serial out driven outside frame");
    a_sdo_drive: assert property ((!par && !cs_n && !write_frame_strobe_n) [*8] |-> !oe[15])
        else $error("serial out not driven in frame");
endmodule : rdc_host_port_asserts

bind rdc_host_port rdc_host_port_asserts u_chk (.clk(clk), .rst_n(rst_n),
    .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n), .rd_n(rd_n),
    .write_frame_strobe_n(write_frame_strobe_n), .serial_port_select(serial_port_select),
    .parallel_data_bus_oe_n(parallel_data_bus_oe_n));

// *** testbench/rdc_host_model.sv ***
// Host controller model driving the converter's pins
`timescale 1ns/1ps
module rdc_host_model (
    input wire logic clk,
    input wire logic [15:0] dev_out,
    input wire logic [15:0] dev_oe_n,
    output logic cs_n,
    output logic rd_n,
    output logic wfs_n,
    output logic sps,
    output logic sample_n,
    output logic mode_hi,
    output logic mode_lo,
    output logic res_hi,
    output logic res_lo,
    output logic [15:0] pin_level
);
    logic [15:0] hen, pat;
    logic [7:0] wbyte;
    logic sclk, sdi;
    wire logic [15:0] hval = {1'b0, sdi, sclk, 5'h00, wbyte};
    initial begin
        {cs_n, rd_n, wfs_n, sps, sample_n, sclk} = 6'h3f;
        {mode_hi, mode_lo, res_hi, res_lo, sdi, wbyte} = '0;
        hen = '0;
        pat = 16'h5555;
    end
    // Released lines toggle so a stale value never passes
    always @(posedge clk) pat <= ~pat;
    assign pin_level = (~dev_oe_n & dev_out) | (dev_oe_n & hen & hval) | (dev_oe_n & ~hen & pat);
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task setup(input logic s, input logic [1:0] m, input logic [1:0] r);
        @(posedge clk);
        sps <= s;
        rd_n <= 1'b1;
        {mode_hi, mode_lo} <= m;
        {res_hi, res_lo} <= r;
        hen <= s ? 16'h0000 : 16'h6000;
        tick(6);
    endtask : setup
    task par_read(input logic cs, output logic [15:0] w, output logic [15:0] oe);
        @(posedge clk);
        cs_n <= cs;
        rd_n <= 1'b0;
        tick(8);
        w = pin_level;
        oe = dev_oe_n;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        tick(8);
    endtask : par_read
    task par_write(input logic [7:0] b);
        @(posedge clk);
        cs_n <= 1'b0;
        wfs_n <= 1'b0;
        hen <= 16'h00ff;
        wbyte <= b;
        tick(6);
        wfs_n <= 1'b1;
        tick(4);
        cs_n <= 1'b1;
        hen <= 16'h0000;
        tick(4);
    endtask : par_write
    task capture;
        @(posedge clk);
        sample_n <= 1'b0;
        tick(6);
        sample_n <= 1'b1;
        tick(6);
    endtask : capture
    // Serial clock keeps its own timing, off the block clock edges
    task serial_frame(input logic [7:0] tx, output logic [23:0] rx);
        @(posedge clk);
        cs_n <= 1'b0;
        wfs_n <= 1'b0;
        tick(8);
        #0.25;
        for (int k = 0; k < 24; k++) begin
            sdi = (k >= 16) ? tx[23-k] : 1'b0;
            #62.5 sclk = 1'b0;
            rx = {rx[22:0], pin_level[15]};
            #62.5 sclk = 1'b1;
        end
        tick(4);
        wfs_n <= 1'b1;
        cs_n <= 1'b1;
        tick(8);
    endtask : serial_frame
endmodule : rdc_host_model

// *** testbench/test_rdc_host_port.sv ***
// Self-checking bench for the resolver converter host port
`timescale 1ns/1ps
`include "rdc_defs.svh"
module test_rdc_host_port;
    import rdc_pkg::*;
    localparam logic [15:0] P = 16'hb6d9;
    localparam logic [15:0] V = 16'h4e27;
    localparam logic [7:0] F = 8'h93;
    localparam logic [15:0] MASK [4] = '{`RDC_MASK_RES10, `RDC_MASK_RES12,
        `RDC_MASK_RES14, `RDC_MASK_RES16};
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0, hrdata;
    logic hreadyout, hresp, cs_n, rd_n, wfs_n, sps, smp_n, m_hi, m_lo, r_hi, r_lo;
    logic [15:0] pos = '0, vel = '0, bus_out, oe_n, level;
    logic [7:0] flt = '0;
    int error_cnt = 0, checks = 0;
    always #4 clk = ~clk;
    rdc_host_port u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .integ_position(pos), .integ_velocity(vel), .fault_flags(flt), .cs_n(cs_n),
        .rd_n(rd_n), .write_frame_strobe_n(wfs_n), .serial_port_select(sps),
        .sample_n(smp_n), .mode_select_hi(m_hi), .mode_select_lo(m_lo),
        .resolution_select_hi(r_hi), .resolution_select_lo(r_lo),
        .parallel_data_bus_in(level), .parallel_data_bus_out(bus_out),
        .parallel_data_bus_oe_n(oe_n));
    rdc_host_model u_host (.clk(clk), .dev_out(bus_out), .dev_oe_n(oe_n), .cs_n(cs_n),
        .rd_n(rd_n), .wfs_n(wfs_n), .sps(sps), .sample_n(smp_n), .mode_hi(m_hi),
        .mode_lo(m_lo), .res_hi(r_hi), .res_lo(r_lo), .pin_level(level));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask : ahb
    task give_verdict;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        logic [31:0] r;
        logic [15:0] w, oe;
        logic [23:0] rx;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(0, `RDC_CTRL_OFS, 0, r);
        chk(r, 32'h1);
        ahb(0, `RDC_CFG_TX_OFS, 0, r);
        chk(r, 32'h0);
        ahb(0, 8'h20, 0, r);
        chk(r, 32'h0);
        ahb(0, `RDC_STATUS_OFS, 0, r);
        chk(r[6:0], 7'h01);
        pos <= P;
        vel <= V;
        flt <= F;
        u_host.capture();
        pos <= 16'h0f0f;
        vel <= 16'hf0f0;
        flt <= 8'h5a;
        u_host.tick(8);
        ahb(0, `RDC_POS_HOLD_OFS, 0, r);
        chk(r, {16'h0, P});
        ahb(0, `RDC_VEL_HOLD_OFS, 0, r);
        chk(r, {16'h0, V});
        ahb(0, `RDC_FAULT_HOLD_OFS, 0, r);
        chk(r, {24'h0, F});
        for (int i = 0; i < 4; i++) begin
            u_host.setup(1, MODE_POSITION, i[1:0]);
            u_host.par_read(0, w, oe);
            chk(w, P & MASK[i]);
            chk(oe, 16'h0000);
            ahb(0, `RDC_STATUS_OFS, 0, r);
            chk(r[4:3], i[1:0]);
        end
        u_host.setup(1, MODE_VELOCITY, RES_14);
        u_host.par_read(0, w, oe);
        chk(w, V & MASK[2]);
        u_host.par_read(1, w, oe);
        chk(oe, 16'hffff);
        ahb(0, `RDC_STATUS_OFS, 0, r);
        chk(r[2:1], MODE_VELOCITY);
        u_host.setup(1, MODE_RESERVED, RES_16);
        u_host.par_read(0, w, oe);
        chk(w, 16'h0000);
        ahb(1, `RDC_CFG_TX_OFS, 32'ha5, r);
        u_host.setup(1, MODE_CONFIG, RES_16);
        u_host.par_read(0, w, oe);
        chk(w, 16'ha500);
        u_host.par_write(8'h3c);
        ahb(0, `RDC_CFG_RX_OFS, 0, r);
        chk(r, 32'h3c);
        ahb(0, `RDC_STATUS_OFS, 0, r);
        chk(r[5], 1'b1);
        ahb(1, `RDC_CFG_CLR_OFS, 32'h1, r);
        ahb(0, `RDC_STATUS_OFS, 0, r);
        chk(r[5], 1'b0);
        u_host.setup(1, MODE_POSITION, RES_16);
        u_host.par_write(8'hc3);
        ahb(1, `RDC_CTRL_OFS, 32'h0, r);
        u_host.setup(1, MODE_CONFIG, RES_16);
        u_host.par_write(8'h77);
        ahb(0, `RDC_CFG_RX_OFS, 0, r);
        chk(r, 32'h3c);
        ahb(1, `RDC_CTRL_OFS, 32'h1, r);
        u_host.setup(0, MODE_POSITION, RES_16);
        ahb(0, `RDC_STATUS_OFS, 0, r);
        chk(r[0], 1'b0);
        u_host.serial_frame(8'h00, rx);
        chk(rx, {P, F});
        ahb(1, `RDC_CFG_TX_OFS, 32'h5a, r);
        u_host.setup(0, MODE_CONFIG, RES_16);
        u_host.serial_frame(8'h96, rx);
        chk(rx, {16'h5a00, F});
        ahb(0, `RDC_CFG_RX_OFS, 0, r);
        chk(r, 32'h96);
        u_host.setup(1, MODE_POSITION, RES_16);
        give_verdict();
    end
endmodule : test_rdc_host_port
